/* dv/fuse_lock_protection_chk.sv */
// concurrent checks on the ports of the fuse and lock logic
`timescale 1ns/100ps
`default_nettype none
`include "fuse_lock_defs.vh"
module fuse_lock_protection_chk #(
	parameter integer SPM_CYCLES = 20
)
(
	input wire clk,
	input wire srst,
	input wire ce,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire [1:0] cmd_addr,
	input wire spm_req,
	input wire resp_refused_reg,
	input wire busy_reg,
	input wire data_erase_req_reg,
	input wire rww_busy_flag_reg,
	input wire spm_refused_reg,
	input wire spm_active_reg,
	input wire spm_done_reg,
	input wire [7:0] fuse_low_q_reg,
	input wire [7:0] fuse_ext_q_reg,
	input wire clock_out_en_reg,
	input wire data_mem_preserve_reg,
	input wire self_program_allowed_reg
);
	// ==================================================
	// timing length
	// counts enabled cycles with the timer running, read when it stops
	reg [19:0] act_cnt_reg;
	always @(posedge clk)
	begin
		if (srst)
			act_cnt_reg <= 20'h00000;
		else if (ce)
			act_cnt_reg <= spm_active_reg ? act_cnt_reg + 20'h00001 : 20'h00000;
	end

	// ==================================================
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	rww_zero_a: assert property (rww_busy_flag_reg == 1'b0)
		else $error("rww busy flag seen high");
	clock_out_a: assert property ($stable(fuse_low_q_reg) |-> clock_out_en_reg == !fuse_low_q_reg[`FLOW_CLOCK_OUT])
		else $error("clock output enable disagrees with fuse");
	ext_ones_a: assert property (fuse_ext_q_reg[7:1] == 7'h7F)
		else $error("unused extended fuse bits not one");
	spm_refuse_a: assert property (spm_req && ce && !self_program_allowed_reg && $stable(self_program_allowed_reg) |=> spm_refused_reg)
		else $error("store accepted with self-program fuse unprogrammed");
	spm_length_a: assert property ($fell(spm_active_reg) |-> act_cnt_reg == SPM_CYCLES)
		else $error("self-program timing length wrong");
	spm_done_a: assert property ($fell(spm_active_reg) |-> ##[0:1] spm_done_reg)
		else $error("no done pulse after timing");
	sig_refuse_a: assert property (cmd_valid && ce && cmd_code == `CMD_READ_SIG && cmd_addr == 2'h3 |=> resp_refused_reg)
		else $error("signature address three not refused");
	erase_refuse_a: assert property (cmd_valid && ce && busy_reg |=> resp_refused_reg)
		else $error("command accepted during chip erase");
	preserve_kept_a: assert property (busy_reg && data_mem_preserve_reg |-> !data_erase_req_reg)
		else $error("data memory erased while preserved");
endmodule

bind fuse_lock_protection fuse_lock_protection_chk #(.SPM_CYCLES(SPM_CYCLES)) i_chk (
	.clk, .srst, .ce, .cmd_valid, .cmd_code, .cmd_addr, .spm_req, .resp_refused_reg, .busy_reg,
	.data_erase_req_reg, .rww_busy_flag_reg, .spm_refused_reg, .spm_active_reg, .spm_done_reg,
	.fuse_low_q_reg, .fuse_ext_q_reg, .clock_out_en_reg, .data_mem_preserve_reg,
	.self_program_allowed_reg);
`default_nettype wire

/* dv/fuse_lock_protection_tb_top.sv */
// self-checking bench for the fuse, lock and signature logic
`timescale 1ns/100ps
`default_nettype none
`include "fuse_lock_defs.vh"
module fuse_lock_protection_tb_top;
	// signature values are arbitrary
	localparam [7:0] SIG0 = 8'h5A;
	localparam [7:0] SIG1 = 8'hA5;
	localparam [7:0] SIG2 = 8'h3C;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic sw_fuse_req = 1'b0;
	logic [1:0] sw_addr = 2'h0;
	logic spm_req = 1'b0;
	logic [1:0] spm_kind = 2'h0;
	logic [1:0] spm_lock_data = 2'h0;
	int mismatches = 0;
	int check_count = 0;
	int i;
	wire prog_mode_pin, cmd_valid, cmd_serial, flash_erase_done, data_erase_done;
	wire [7:0] cmd_code, cmd_data, resp_data_reg, sw_data_reg;
	wire [1:0] cmd_addr;
	wire resp_valid_reg, resp_refused_reg, busy_reg, mem_write_go_reg, mem_read_go_reg;
	wire flash_erase_req_reg, data_erase_req_reg, rww_busy_flag_reg, spm_refused_reg;
	wire spm_active_reg, spm_done_reg, clock_out_en_reg, data_mem_preserve_reg;
	wire self_program_allowed_reg;
	wire [7:0] fuse_low_q_reg, fuse_high_q_reg, fuse_ext_q_reg;

	always #5 clk = ~clk;

	fuse_lock_protection #(.MAKER_SIG(SIG0), .SIZE_SIG(SIG1), .PART_SIG(SIG2), .SPM_CYCLES(20))
	i_dut (.clk, .srst, .ce, .prog_mode_pin, .cmd_valid, .cmd_code, .cmd_serial, .cmd_addr,
		.cmd_data, .flash_erase_done, .data_erase_done, .sw_fuse_req, .sw_addr, .spm_req, .spm_kind,
		.spm_lock_data, .resp_valid_reg, .resp_refused_reg, .resp_data_reg, .busy_reg,
		.mem_write_go_reg, .mem_read_go_reg, .flash_erase_req_reg, .data_erase_req_reg,
		.sw_data_reg, .rww_busy_flag_reg, .spm_refused_reg, .spm_active_reg, .spm_done_reg,
		.fuse_low_q_reg, .fuse_high_q_reg, .fuse_ext_q_reg, .clock_out_en_reg,
		.data_mem_preserve_reg, .self_program_allowed_reg);

	prog_model i_prog (.clk, .resp_valid_reg, .resp_refused_reg, .resp_data_reg,
		.flash_erase_req_reg, .data_erase_req_reg, .prog_mode_pin, .cmd_valid, .cmd_code,
		.cmd_serial, .cmd_addr, .cmd_data, .flash_erase_done, .data_erase_done);

	// ==================================================
	// shared tasks
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// command plus refusal check, the answer must always come
	task automatic pc(input logic [7:0] code, input logic [1:0] a, input logic [7:0] d,
		input logic ser, input logic refd);
		i_prog.send(code, a, d, ser);
		cmp8({7'h00, i_prog.got_valid}, 8'h01);
		cmp8({7'h00, i_prog.got_ref}, {7'h00, refd});
	endtask

	task automatic swrd(input logic [1:0] a, input logic [7:0] exp);
		@(negedge clk);
		sw_addr = a;
		sw_fuse_req = 1'b1;
		@(negedge clk);
		sw_fuse_req = 1'b0;
		cmp8(sw_data_reg, exp);
	endtask

	task automatic spm(input logic [1:0] k, input logic [1:0] d, input logic refd);
		@(negedge clk);
		spm_kind = k;
		spm_lock_data = d;
		spm_req = 1'b1;
		@(negedge clk);
		spm_req = 1'b0;
		cmp8({7'h00, spm_refused_reg}, {7'h00, refd});
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==================================================
	// scenarios
	task automatic t_defaults;
		cmp8(fuse_low_q_reg, 8'h62);
		cmp8(fuse_high_q_reg, 8'hDF);
		cmp8(fuse_ext_q_reg, 8'hFF);
		swrd(2'h0, 8'h62);
		swrd(2'h1, 8'hFF);
		swrd(2'h2, 8'hFF);
		swrd(2'h3, 8'hDF);
		cmp8({7'h00, clock_out_en_reg, data_mem_preserve_reg}, 8'h00);
		spm(`SPM_PAGE_WRITE, 2'h0, 1'b1);
	endtask

	task automatic t_fuses;
		i_prog.mode(1'b1);
		pc(`CMD_READ_SIG, 2'h0, 8'h00, 1'b0, 1'b0);
		cmp8(i_prog.got_data, SIG0);
		pc(`CMD_READ_SIG, 2'h1, 8'h00, 1'b1, 1'b0);
		cmp8(i_prog.got_data, SIG1);
		pc(`CMD_READ_SIG, 2'h2, 8'h00, 1'b0, 1'b0);
		cmp8(i_prog.got_data, SIG2);
		pc(`CMD_READ_SIG, 2'h3, 8'h00, 1'b0, 1'b1);
		pc(`CMD_WRITE_FUSE, `SEL_FUSE_EXT, 8'h00, 1'b0, 1'b0);
		pc(`CMD_READ_FUSE, `SEL_FUSE_EXT, 8'h00, 1'b0, 1'b0);
		cmp8(i_prog.got_data, 8'hFE);
		cmp8(fuse_ext_q_reg, 8'hFF);
		pc(`CMD_WRITE_FUSE, `SEL_FUSE_HIGH, 8'hF7, 1'b1, 1'b0);
		pc(`CMD_READ_FUSE, `SEL_FUSE_HIGH, 8'h00, 1'b0, 1'b0);
		cmp8(i_prog.got_data, 8'hD7);
		cmp8({7'h00, data_mem_preserve_reg}, 8'h01);
		i_prog.mode(1'b0);
		cmp8(fuse_ext_q_reg, 8'hFE);
		cmp8({7'h00, self_program_allowed_reg}, 8'h01);
	endtask

	task automatic t_spm;
		spm(2'h3, 2'h0, 1'b1);
		spm(`SPM_LOCK_WRITE, 2'h2, 1'b0);
		for (i = 0; i < 100 && spm_done_reg !== 1'b1; i++)
			@(negedge clk);
		cmp8({7'h00, spm_done_reg}, 8'h01);
		repeat (2) @(negedge clk);
		swrd(`SEL_LOCK, 8'hFE);
	endtask

	task automatic t_locks;
		i_prog.mode(1'b1);
		pc(`CMD_WRITE_FLASH, 2'h0, 8'h00, 1'b0, 1'b1);
		cmp8({7'h00, mem_write_go_reg}, 8'h00);
		pc(`CMD_READ_FLASH, 2'h0, 8'h00, 1'b0, 1'b0);
		cmp8({7'h00, mem_read_go_reg}, 8'h01);
		pc(`CMD_WRITE_FUSE, `SEL_FUSE_LOW, 8'hFF, 1'b0, 1'b1);
		pc(`CMD_WRITE_LOCK, 2'h0, 8'h00, 1'b0, 1'b0);
		pc(`CMD_READ_DATA, 2'h0, 8'h00, 1'b0, 1'b1);
		pc(`CMD_WRITE_DATA, 2'h0, 8'h00, 1'b0, 1'b1);
		pc(`CMD_READ_SIG, 2'h0, 8'h00, 1'b1, 1'b0);
		pc(`CMD_CHIP_ERASE, 2'h0, 8'h00, 1'b0, 1'b0);
		pc(`CMD_READ_FUSE, `SEL_LOCK, 8'h00, 1'b0, 1'b1);
		for (i = 0; i < 100 && busy_reg === 1'b1; i++)
			@(negedge clk);
		pc(`CMD_READ_FUSE, `SEL_LOCK, 8'h00, 1'b0, 1'b0);
		cmp8(i_prog.got_data, 8'hFF);
		pc(`CMD_READ_FUSE, `SEL_FUSE_HIGH, 8'h00, 1'b0, 1'b0);
		cmp8(i_prog.got_data, 8'hD7);
		pc(`CMD_WRITE_FLASH, 2'h0, 8'h00, 1'b0, 1'b0);
		cmp8({7'h00, mem_write_go_reg}, 8'h01);
		// preserve fuse back to unprogrammed, so the next erase clears data memory
		pc(`CMD_WRITE_FUSE, `SEL_FUSE_HIGH, 8'hFF, 1'b0, 1'b0);
		pc(`CMD_CHIP_ERASE, 2'h0, 8'h00, 1'b0, 1'b0);
		for (i = 0; i < 100 && busy_reg === 1'b1; i++)
			@(negedge clk);
		cmp8(i_prog.derase_cnt, 8'h01);
		pc(`CMD_WRITE_LOCK, 2'h0, 8'h01, 1'b0, 1'b0);
		pc(`CMD_READ_FLASH, 2'h0, 8'h00, 1'b0, 1'b1);
		pc(8'hFF, 2'h0, 8'h00, 1'b0, 1'b1);
		i_prog.mode(1'b0);
	endtask

	// ==================================================
	// main sequence and watchdog
	initial
	begin
		repeat (12) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		t_defaults();
		t_fuses();
		t_spm();
		// t_spm has already programmed the low lock bit, so t_locks starts with fuses locked
		t_locks();
		complete_run();
	end

	initial
	begin
		#200000;
		mismatches++;
		complete_run();
	end
endmodule
`default_nettype wire

/* dv/prog_model.sv */
// programmer and memory-array model on the far side of the fuse and lock logic
`timescale 1ns/100ps
`default_nettype none
module prog_model
(
	input wire clk,
	input wire resp_valid_reg,
	input wire resp_refused_reg,
	input wire [7:0] resp_data_reg,
	input wire flash_erase_req_reg,
	input wire data_erase_req_reg,
	output logic prog_mode_pin,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic cmd_serial,
	output logic [1:0] cmd_addr,
	output logic [7:0] cmd_data,
	output logic flash_erase_done,
	output logic data_erase_done
);
	logic got_valid = 1'b0;
	logic got_ref = 1'b0;
	logic [7:0] got_data = 8'h00;
	logic [3:0] fcnt = 4'h0;
	logic [3:0] dcnt = 4'h0;
	logic [7:0] derase_cnt = 8'h00;

	// ==================================================
	// idle pins
	initial
	begin
		prog_mode_pin = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_serial = 1'b0;
		cmd_addr = 2'h0;
		cmd_data = 8'h00;
	end

	// ==================================================
	// arrays take several cycles to erase, done is a single pulse
	always @(negedge clk)
	begin
		fcnt <= flash_erase_req_reg ? 4'h6 : (fcnt != 4'h0 ? fcnt - 4'h1 : 4'h0);
		dcnt <= data_erase_req_reg ? 4'h4 : (dcnt != 4'h0 ? dcnt - 4'h1 : 4'h0);
		if (data_erase_req_reg === 1'b1)
			derase_cnt <= derase_cnt + 8'h01;
	end
	assign flash_erase_done = (fcnt == 4'h1);
	assign data_erase_done = (dcnt == 4'h1);

	// ==================================================
	// level change, then enough cycles for the synchroniser
	task automatic mode(input logic v);
		@(negedge clk);
		prog_mode_pin = v;
		repeat (8) @(negedge clk);
	endtask

	// one command, answer taken the cycle after
	task automatic send(input logic [7:0] code, input logic [1:0] addr, input logic [7:0] data,
		input logic ser);
		@(negedge clk);
		cmd_code = code;
		cmd_addr = addr;
		cmd_data = data;
		cmd_serial = ser;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		got_valid = resp_valid_reg;
		got_ref = resp_refused_reg;
		got_data = resp_data_reg;
		// unqualified lines must not hold the last value
		cmd_code = ~code;
		cmd_addr = ~addr;
		cmd_data = ~data;
	endtask
endmodule
`default_nettype wire

/* rtl/fuse_lock_defs.vh */
// constants for the fuse, lock and signature logic
`ifndef FUSE_LOCK_DEFS_VH
`define FUSE_LOCK_DEFS_VH

// ==================================================
// programmer command bytes
`define CMD_CHIP_ERASE 8'h80
`define CMD_WRITE_FUSE 8'h40
`define CMD_WRITE_LOCK 8'h20
`define CMD_WRITE_FLASH 8'h10
`define CMD_WRITE_DATA 8'h11
`define CMD_READ_SIG 8'h08
`define CMD_READ_FUSE 8'h04
`define CMD_READ_FLASH 8'h02
`define CMD_READ_DATA 8'h03

// ==================================================
// fuse and lock byte selectors (software pointer addresses)
`define SEL_FUSE_LOW 2'h0
`define SEL_LOCK 2'h1
`define SEL_FUSE_EXT 2'h2
`define SEL_FUSE_HIGH 2'h3

// ==================================================
// signature addresses
`define SIG_ADDR_MAKER 2'h0
`define SIG_ADDR_SIZE 2'h1
`define SIG_ADDR_PART 2'h2

// ==================================================
// field positions
`define FEXT_SELF_PROG 0
`define FHIGH_EXT_RESET_DIS 7
`define FHIGH_DEBUG 6
`define FHIGH_SERIAL_PROG 5
`define FHIGH_WDOG_FORCED 4
`define FHIGH_PRESERVE 3
`define FLOW_DIV_EIGHT 7
`define FLOW_CLOCK_OUT 6
`define LOCK_LOW_BIT 0
`define LOCK_HIGH_BIT 1

// ==================================================
// erased (reset) values, programmed bits read 0
`define FUSE_LOW_RESET 8'h62
`define FUSE_HIGH_RESET 8'hDF
`define FUSE_EXT_RESET 8'hFF
`define LOCK_RESET 8'hFF
`define LOCK_BITS_RESET 2'h3

// ==================================================
// self-programmed flash write time
`define SPM_TIME_MIN_NS 3700000
`define SPM_TIME_MAX_NS 4500000
`define CLK_PERIOD_NS 10
`define SPM_CYCLES ((`SPM_TIME_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// self-program operation kinds
`define SPM_PAGE_ERASE 2'h0
`define SPM_PAGE_WRITE 2'h1
`define SPM_LOCK_WRITE 2'h2

`endif

/* rtl/fuse_lock_protection.v */
// fuse, lock-bit and signature logic of the non-volatile memory subsystem
// How it works
// R1: self-program erase, write and lock write timed 3.7 to 4.5 ms
// R2: read-while-write busy flag always reads zero
// R3: two lock bits, 1 unprogrammed; only chip erase returns them to 1
// R4: both lock bits 1: no restriction on programming or verification
// R5: high 1, low 0: memory programming refused, fuses locked
// R6: both 0: memory programming and read-back refused, fuses locked
// R7: programmer should program fuses before any lock bit
// R8: three fuse bytes, programmed reads 0, unprogrammed reads 1
// R9: self-program store allowed only when self-program fuse is 0
// R10: extended byte bit 0 self-program fuse, bits 7..1 read 1
// R11: high byte layout; serial programming fuse defaults programmed
// R12: serial programming fuse not alterable over the serial interface
// R13: preserve fuse programmed keeps data memory across chip erase
// R14: low byte layout, defaults divide-by-eight, start-up 10, source 0010
// R15: clock output fuse programmed drives system clock to the port pin
// R16: fuses latched on programming-mode entry, effective after exit
// R17: preserve fuse acts at once, without waiting for latching
// R18: fuses also latched at power-up in normal mode
// R19: three signature bytes at 0..2, readable even when locked
// R20: signature bytes give maker, flash size and part
// R21: software reads lock, fuse low, ext, high at pointers 1,0,2,3
// R22: chip erase resets lock bits after flash erase, fuses untouched
// R23: lock combination high 0, low 1 acts as the strictest level
`timescale 1ns/100ps
`default_nettype none
`include "fuse_lock_defs.vh"

module fuse_lock_protection #(
	parameter [7:0] MAKER_SIG = 8'h5A,
	parameter [7:0] SIZE_SIG = 8'hA5,
	parameter [7:0] PART_SIG = 8'h3C,
	parameter integer SPM_CYCLES = `SPM_CYCLES,
	parameter integer SPM_WIDTH = 19
)
(
	input wire clk,
	input wire srst,
	input wire ce,
	input wire prog_mode_pin,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire cmd_serial,
	input wire [1:0] cmd_addr,
	input wire [7:0] cmd_data,
	input wire flash_erase_done,
	input wire data_erase_done,
	input wire sw_fuse_req,
	input wire [1:0] sw_addr,
	input wire spm_req,
	input wire [1:0] spm_kind,
	input wire [1:0] spm_lock_data,
	output reg resp_valid_reg,
	output reg resp_refused_reg,
	output reg [7:0] resp_data_reg,
	output reg busy_reg,
	output reg mem_write_go_reg,
	output reg mem_read_go_reg,
	output reg flash_erase_req_reg,
	output reg data_erase_req_reg,
	output reg [7:0] sw_data_reg,
	output reg rww_busy_flag_reg,
	output reg spm_refused_reg,
	output wire spm_active_reg,
	output wire spm_done_reg,
	output reg [7:0] fuse_low_q_reg,
	output reg [7:0] fuse_high_q_reg,
	output reg [7:0] fuse_ext_q_reg,
	output reg clock_out_en_reg,
	output reg data_mem_preserve_reg,
	output reg self_program_allowed_reg
);

// ==================================================
// states of the chip erase sequence
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_ERASE_FLASH = 2'h1;
localparam [1:0] ST_ERASE_DATA = 2'h2;

// non-volatile cells; a reset stands for a fresh, erased part
reg [7:0] fuse_low_reg;
reg [7:0] fuse_high_reg;
reg [7:0] fuse_ext_reg;
reg [1:0] lock_reg;
reg [1:0] state_reg;
reg [1:0] spm_kind_reg;
reg [1:0] spm_lock_data_reg;
reg prog_s1_reg;
reg prog_s2_reg;
reg prog_s3_reg;
reg prog_q_reg;
reg prog_prev_reg;
reg power_up_reg;
reg spm_start_reg;

wire [7:0] lock_byte;
wire wr_block;
wire rd_block;
wire fuse_block;
wire cmd_take;
wire prog_edge;
wire [7:0] high_wr;
wire spm_ok;

// ==================================================
// lock byte: unused bits read as unprogrammed
assign lock_byte = {6'h3F, lock_reg};
// R4: no restriction
// R5: memory writes refused
// R23: unlisted combination
assign wr_block = (lock_reg != 2'b11);
// R6: read-back refused
assign rd_block = ~lock_reg[`LOCK_HIGH_BIT];
assign fuse_block = wr_block;
assign cmd_take = cmd_valid && prog_q_reg && (state_reg == ST_IDLE);
assign prog_edge = prog_q_reg ^ prog_prev_reg;
// R12: serial port keeps the serial programming fuse
assign high_wr = cmd_serial ?
	{cmd_data[7:6], fuse_high_reg[`FHIGH_SERIAL_PROG], cmd_data[4:0]} : cmd_data;
// R9: self-program allowed when fuse programmed
assign spm_ok = self_program_allowed_reg & ~prog_q_reg & ~spm_active_reg;

// ==================================================
// programming-mode pin synchroniser; a level counts once s2 and s3 agree
always @(posedge clk)
begin
	if (srst)
	begin
		prog_s1_reg <= 1'b0;
		prog_s2_reg <= 1'b0;
		prog_s3_reg <= 1'b0;
		prog_q_reg <= 1'b0;
		prog_prev_reg <= 1'b0;
	end
	else if (ce)
	begin
		prog_s1_reg <= prog_mode_pin;
		prog_s2_reg <= prog_s1_reg;
		prog_s3_reg <= prog_s2_reg;
		if (prog_s2_reg == prog_s3_reg)
			prog_q_reg <= prog_s3_reg;
		prog_prev_reg <= prog_q_reg;
	end
end

// ==================================================
// fuse latching; latched copies drive the clock-output and self-program controls, preserve uses the live cell
always @(posedge clk)
begin
	if (srst)
	begin
		power_up_reg <= 1'b1;
		fuse_low_q_reg <= `FUSE_LOW_RESET;
		fuse_high_q_reg <= `FUSE_HIGH_RESET;
		fuse_ext_q_reg <= `FUSE_EXT_RESET;
	end
	else if (ce)
	begin
		power_up_reg <= 1'b0;
		// R18: power-up latch
		// R16: latch on entry, exit releases the new values
		if (power_up_reg || prog_edge)
		begin
			fuse_low_q_reg <= fuse_low_reg;
			fuse_high_q_reg <= fuse_high_reg;
			fuse_ext_q_reg <= fuse_ext_reg;
		end
	end
end

// ==================================================
// derived controls
always @(posedge clk)
begin
	if (srst)
	begin
		clock_out_en_reg <= 1'b0;
		data_mem_preserve_reg <= 1'b0;
		self_program_allowed_reg <= 1'b0;
		rww_busy_flag_reg <= 1'b0;
	end
	else if (ce)
	begin
		// R15: clock out when fuse programmed
		clock_out_en_reg <= ~fuse_low_q_reg[`FLOW_CLOCK_OUT];
		// R17: preserve follows the live cell
		data_mem_preserve_reg <= ~fuse_high_reg[`FHIGH_PRESERVE];
		self_program_allowed_reg <= ~fuse_ext_q_reg[`FEXT_SELF_PROG];
		// R2: no read-while-write support
		rww_busy_flag_reg <= 1'b0;
	end
end

// ==================================================
// programmer commands, chip erase sequence and cell updates
always @(posedge clk)
begin
	if (srst)
	begin
		// R8: erased cells; R10, R11, R14 defaults
		fuse_low_reg <= `FUSE_LOW_RESET;
		fuse_high_reg <= `FUSE_HIGH_RESET;
		fuse_ext_reg <= `FUSE_EXT_RESET;
		lock_reg <= `LOCK_BITS_RESET;
		state_reg <= ST_IDLE;
		resp_valid_reg <= 1'b0;
		resp_refused_reg <= 1'b0;
		resp_data_reg <= 8'h00;
		busy_reg <= 1'b0;
		mem_write_go_reg <= 1'b0;
		mem_read_go_reg <= 1'b0;
		flash_erase_req_reg <= 1'b0;
		data_erase_req_reg <= 1'b0;
	end
	else if (ce)
	begin
		resp_valid_reg <= 1'b0;
		resp_refused_reg <= 1'b0;
		mem_write_go_reg <= 1'b0;
		mem_read_go_reg <= 1'b0;
		flash_erase_req_reg <= 1'b0;
		data_erase_req_reg <= 1'b0;
		// every command is answered, refused while erasing or out of mode
		if (cmd_valid)
		begin
			resp_valid_reg <= 1'b1;
			resp_data_reg <= 8'hFF;
			resp_refused_reg <= ~cmd_take;
		end
		case (state_reg)
		ST_IDLE:
		begin
			if (cmd_take)
			begin
				case (cmd_code)
				`CMD_CHIP_ERASE:
				begin
					busy_reg <= 1'b1;
					flash_erase_req_reg <= 1'b1;
					state_reg <= ST_ERASE_FLASH;
				end
				`CMD_WRITE_FUSE:
				begin
					// R5: fuses locked
					if (fuse_block)
						resp_refused_reg <= 1'b1;
					else if (cmd_addr == `SEL_FUSE_LOW)
						fuse_low_reg <= cmd_data;
					else if (cmd_addr == `SEL_FUSE_HIGH)
						fuse_high_reg <= high_wr;
					else if (cmd_addr == `SEL_FUSE_EXT)
						// R10: unused bits stay 1
						fuse_ext_reg <= {7'h7F, cmd_data[`FEXT_SELF_PROG]};
					else
						resp_refused_reg <= 1'b1;
				end
				// R3: lock bits only move toward programmed
				`CMD_WRITE_LOCK: lock_reg <= lock_reg & cmd_data[1:0];
				`CMD_WRITE_FLASH, `CMD_WRITE_DATA:
				begin
					// R5: memory writes refused when locked
					if (wr_block)
						resp_refused_reg <= 1'b1;
					else
						mem_write_go_reg <= 1'b1;
				end
				`CMD_READ_FLASH, `CMD_READ_DATA:
				begin
					// R6: verification refused at the strict level
					if (rd_block)
						resp_refused_reg <= 1'b1;
					else
						mem_read_go_reg <= 1'b1;
				end
				`CMD_READ_SIG:
				begin
					// R19: signature ignores the lock level
					// R20: maker, size, part
					case (cmd_addr)
					`SIG_ADDR_MAKER: resp_data_reg <= MAKER_SIG;
					`SIG_ADDR_SIZE: resp_data_reg <= SIZE_SIG;
					`SIG_ADDR_PART: resp_data_reg <= PART_SIG;
					default: resp_refused_reg <= 1'b1;
					endcase
				end
				`CMD_READ_FUSE:
				begin
					case (cmd_addr)
					`SEL_FUSE_LOW: resp_data_reg <= fuse_low_reg;
					`SEL_LOCK: resp_data_reg <= lock_byte;
					`SEL_FUSE_EXT: resp_data_reg <= fuse_ext_reg;
					default: resp_data_reg <= fuse_high_reg;
					endcase
				end
				default: resp_refused_reg <= 1'b1;
				endcase
			end
			// self-programmed lock write lands when the timer ends, if in ST_IDLE and no command is taken that cycle
			else if (spm_done_reg && (spm_kind_reg == `SPM_LOCK_WRITE))
				lock_reg <= lock_reg & spm_lock_data_reg;
		end
		ST_ERASE_FLASH:
		begin
			if (flash_erase_done)
			begin
				// R22: locks cleared only after flash is gone, fuses kept
				lock_reg <= `LOCK_BITS_RESET;
				// R13: preserve fuse skips the data memory
				if (fuse_high_reg[`FHIGH_PRESERVE])
				begin
					data_erase_req_reg <= 1'b1;
					state_reg <= ST_ERASE_DATA;
				end
				else
				begin
					busy_reg <= 1'b0;
					state_reg <= ST_IDLE;
				end
			end
		end
		ST_ERASE_DATA:
		begin
			if (data_erase_done)
			begin
				busy_reg <= 1'b0;
				state_reg <= ST_IDLE;
			end
		end
		default: state_reg <= ST_IDLE;
		endcase
	end
end

// ==================================================
// software read of fuse and lock bytes, answered the next cycle
always @(posedge clk)
begin
	if (srst)
		sw_data_reg <= 8'hFF;
	else if (ce && sw_fuse_req)
	begin
		// R21: pointer 0 low, 1 lock, 2 extended, 3 high
		case (sw_addr)
		`SEL_FUSE_LOW: sw_data_reg <= fuse_low_reg;
		`SEL_LOCK: sw_data_reg <= lock_byte;
		`SEL_FUSE_EXT: sw_data_reg <= fuse_ext_reg;
		default: sw_data_reg <= fuse_high_reg;
		endcase
	end
end

// ==================================================
// self-program request capture; a refused request is simply dropped
always @(posedge clk)
begin
	if (srst)
	begin
		spm_start_reg <= 1'b0;
		spm_refused_reg <= 1'b0;
		spm_kind_reg <= `SPM_PAGE_ERASE;
		spm_lock_data_reg <= 2'b11;
	end
	else if (ce)
	begin
		spm_start_reg <= 1'b0;
		spm_refused_reg <= 1'b0;
		if (spm_req && !spm_start_reg)
		begin
			// R9: store disabled when fuse unprogrammed
			if (spm_ok && (spm_kind != 2'h3))
			begin
				spm_start_reg <= 1'b1;
				spm_kind_reg <= spm_kind;
				spm_lock_data_reg <= spm_lock_data;
			end
			else
				spm_refused_reg <= 1'b1;
		end
	end
end

// R1: fixed write time inside the allowed window
spm_timer #(
	.CYCLES(SPM_CYCLES),
	.WIDTH(SPM_WIDTH)
) u_spm_timer (
	.clk(clk),
	.srst(srst),
	.ce(ce),
	.start(spm_start_reg),
	.busy_reg(spm_active_reg),
	.done_reg(spm_done_reg)
);

endmodule
`default_nettype wire

/* rtl/spm_timer.v */
// one-shot timer for self-programmed flash operations
`timescale 1ns/100ps
`default_nettype none

module spm_timer #(
	parameter integer CYCLES = 370000,
	parameter integer WIDTH = 19
)
(
	input wire clk,
	input wire srst,
	input wire ce,
	input wire start,
	output reg busy_reg,
	output reg done_reg
);

reg [WIDTH-1:0] count_reg;

// ==================================================
// countdown, start ignored while already running
always @(posedge clk)
begin
	if (srst)
	begin
		busy_reg <= 1'b0;
		done_reg <= 1'b0;
		count_reg <= {WIDTH{1'b0}};
	end
	else if (ce)
	begin
		done_reg <= 1'b0;
		if (!busy_reg && start)
		begin
			busy_reg <= 1'b1;
			count_reg <= CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
		end
		else if (busy_reg)
		begin
			if (count_reg == {WIDTH{1'b0}})
			begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end
			else
				count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
end

endmodule
`default_nettype wire
